// *** shared/sro_regs.vh ***
/*
 sample readout register group: offsets, field positions, reset values.
 assumes byte-wide registers on a plain address/strobe port.
*/
`ifndef SRO_REGS_VH
`define SRO_REGS_VH
`define SRO_ADDR_W 8
`define SRO_X_SHORT 8'h08
`define SRO_Y_SHORT 8'h09
`define SRO_Z_SHORT 8'h0a
`define SRO_CNT_LOW 8'h0c
`define SRO_CNT_HIGH 8'h0d
`define SRO_X_HIGH 8'h0e
`define SRO_X_LOW 8'h0f
`define SRO_Y_HIGH 8'h10
`define SRO_Y_LOW 8'h11
`define SRO_Z_HIGH 8'h12
`define SRO_Z_LOW 8'h13
`define SRO_DATA_LAST 8'h17
`define SRO_IRQ_STAT 8'h20
`define SRO_IRQ_EN 8'h21
`define SRO_IRQ_CLR 8'h22
`define SRO_NEW_DATA 8'h23
`define SRO_RESET_VAL 8'h00
`define SRO_CNT_MAX 10'h200
`define SRO_EV_SAMPLE 0
`define SRO_EV_DATA_READY 1
`define SRO_EV_W 2
`endif

// *** hw/sro_axis_reg.v ***
/*
 one axis: holds a 14-bit sample, splits it into high/low/short bytes.
 assumes sample load pulse one cycle; high read snapshots low field.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sro_regs.vh"
module sro_axis_reg (
  // clock and reset
  input wire mclk,
  input wire sys_rst,
  // sample load
  input wire load,
  input wire [13:0] sample,
  // host read of high byte
  input wire high_rd,
  // register views
  output wire [7:0] high_byte,
  output wire [7:0] low_byte,
  output wire [7:0] short_byte
);
  reg [13:0] value_r;
  reg [5:0] low_hold_r;
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      value_r <= 14'h0000;
      low_hold_r <= 6'h00;
    end else begin
      if (load) begin
        value_r <= sample;
      end
      // snapshot so a pair stays coherent across a new sample
      if (high_rd) begin
        low_hold_r <= value_r[5:0];
      end
    end
  end
  assign high_byte = value_r[13:6];
  assign low_byte = {low_hold_r, 2'b00};
  // short view is simply the top byte of the full word
  assign short_byte = value_r[13:6];
endmodule // sro_axis_reg
`default_nettype wire

// *** hw/sro_irq.v ***
/*
 sticky event status, enable and write-one-clear, one level interrupt.
 assumes event pulses one cycle; set wins over clear.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sro_regs.vh"
module sro_irq (
  // clock and reset
  input wire mclk,
  input wire sys_rst,
  // events and software controls
  input wire [`SRO_EV_W-1:0] events,
  input wire en_wr,
  input wire clr_wr,
  input wire [`SRO_EV_W-1:0] wdata,
  // state
  output reg [`SRO_EV_W-1:0] status_r,
  output reg [`SRO_EV_W-1:0] enable_r,
  output wire irq
);
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      status_r <= {`SRO_EV_W{1'b0}};
      enable_r <= {`SRO_EV_W{1'b0}};
    end else begin
      status_r <= (status_r & ~(clr_wr ? wdata : {`SRO_EV_W{1'b0}})) | events;
      if (en_wr) begin
        enable_r <= wdata;
      end
    end
  end
  assign irq = |(status_r & enable_r);
endmodule // sro_irq
`default_nettype wire

// *** hw/sro_readout.v ***
/*
 sample readout register group: buffer fill count, three axes with
 high/low/short views, new-data flag and interrupt.
 assumes one clock, reads answer one cycle later, samples as one-cycle
 pulses synchronous to mclk.
 register map, all byte wide:
   0x08 x short view, top byte of the x word
   0x09 y short view
   0x0a z short view
   0x0c fill count bits 7:0
   0x0d fill count bits 9:8 in 1:0, rest zero
   0x0e x high, word bits 13:6
   0x0f x low, word bits 5:0 in 7:2
   0x10 y high
   0x11 y low
   0x12 z high
   0x13 z low
   0x14..0x17 not held here, read zero
   0x20 event status, read only
   0x21 event enable
   0x22 event clear, write one to clear
   0x23 new-data flag in bit 0
 unmapped addresses read zero and writes there are dropped.
 a low read with no high read before it returns the last snapshot.
 timing:
   an access is taken at the rising edge where rd or wr is high.
   read data stand in the following cycle only, zero otherwise.
   a sample pulse loads all three axes at once; the flag is set at the
   same edge, and the count is registered from its input at every edge.
   a high read snapshots the low field, so the low read after it
   belongs to the same sample even if a new one lands between.
   the pair breaks on any other access in between, read or write.
   a sample that lands during a data read is parked and raises the
   flag on the first cycle without a data read.
   the status bits are sticky; a clear in the same cycle as an event
   loses to the event.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sro_regs.vh"
module sro_readout (
  // clock and reset
  input wire mclk,
  input wire sys_rst,
  // register port
  input wire [`SRO_ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  // sample source
  input wire sample_valid,
  input wire [13:0] x_accel_value,
  input wire [13:0] y_accel_value,
  input wire [13:0] z_accel_value,
  // buffer occupancy
  input wire [9:0] buffer_fill_count,
  // flag and interrupt
  output wire new_data,
  output wire irq
);
  localparam ST_IDLE = 2'd0;
  localparam ST_X = 2'd1;
  localparam ST_Y = 2'd2;
  localparam ST_Z = 2'd3;

  function is_data_addr;
    input [`SRO_ADDR_W-1:0] a;
    begin
      is_data_addr = (a >= `SRO_X_SHORT && a <= `SRO_Z_SHORT) ||
        (a >= `SRO_X_HIGH && a <= `SRO_DATA_LAST);
    end
  endfunction

  // counts above the buffer depth can only come from a faulty source
  function [9:0] clamp_count;
    input [9:0] c;
    begin
      if (c > `SRO_CNT_MAX) begin
        clamp_count = `SRO_CNT_MAX;
      end else begin
        clamp_count = c;
      end
    end
  endfunction

  reg [1:0] pair_r;
  reg [1:0] pair_nxt;
  reg flag_r;
  reg flag_nxt;
  reg pend_r;
  reg [9:0] count_r;
  reg [7:0] rdata_nxt;
  reg pair_done;

  wire [7:0] xh;
  wire [7:0] xl;
  wire [7:0] xs;
  wire [7:0] yh;
  wire [7:0] yl;
  wire [7:0] ys;
  wire [7:0] zh;
  wire [7:0] zl;
  wire [7:0] zs;
  wire [`SRO_EV_W-1:0] ev_status;
  wire [`SRO_EV_W-1:0] ev_enable;
  wire [`SRO_EV_W-1:0] ev_pulse;
  wire data_rd;
  wire x_high_rd;
  wire y_high_rd;
  wire z_high_rd;
  wire irq_en_wr;
  wire irq_clr_wr;
  wire flag_rise;

  // decoded strobes
  assign data_rd = rd && is_data_addr(addr);
  assign x_high_rd = rd && (addr == `SRO_X_HIGH);
  assign y_high_rd = rd && (addr == `SRO_Y_HIGH);
  assign z_high_rd = rd && (addr == `SRO_Z_HIGH);
  assign irq_en_wr = wr && (addr == `SRO_IRQ_EN);
  assign irq_clr_wr = wr && (addr == `SRO_IRQ_CLR);
  // taken from the next value so the status bit lands with the flag
  assign flag_rise = flag_nxt & ~flag_r;
  assign ev_pulse = {flag_rise, sample_valid};

  sro_axis_reg u_x (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .load(sample_valid),
    .sample(x_accel_value),
    .high_rd(x_high_rd),
    .high_byte(xh),
    .low_byte(xl),
    .short_byte(xs)
  );
  sro_axis_reg u_y (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .load(sample_valid),
    .sample(y_accel_value),
    .high_rd(y_high_rd),
    .high_byte(yh),
    .low_byte(yl),
    .short_byte(ys)
  );
  sro_axis_reg u_z (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .load(sample_valid),
    .sample(z_accel_value),
    .high_rd(z_high_rd),
    .high_byte(zh),
    .low_byte(zl),
    .short_byte(zs)
  );

  // which high byte was the last access; any other access breaks the pair
  always @* begin
    pair_nxt = ST_IDLE;
    pair_done = 1'b0;
    if (rd || wr) begin
      case (addr)
        `SRO_X_HIGH: pair_nxt = rd ? ST_X : ST_IDLE;
        `SRO_Y_HIGH: pair_nxt = rd ? ST_Y : ST_IDLE;
        `SRO_Z_HIGH: pair_nxt = rd ? ST_Z : ST_IDLE;
        default: pair_nxt = ST_IDLE;
      endcase
      if (rd) begin
        case (pair_r)
          ST_X: pair_done = (addr == `SRO_X_LOW);
          ST_Y: pair_done = (addr == `SRO_Y_LOW);
          ST_Z: pair_done = (addr == `SRO_Z_LOW);
          default: pair_done = 1'b0;
        endcase
      end
    end else begin
      pair_nxt = pair_r;
    end
  end

  // new-data flag; a sample during a data read waits in pend_r
  always @* begin
    flag_nxt = flag_r;
    if (pair_done) begin
      flag_nxt = 1'b0;
    end
    if (!data_rd && (sample_valid || pend_r)) begin
      flag_nxt = 1'b1;
    end
  end

  // pair tracker
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pair_r <= ST_IDLE;
    end else begin
      pair_r <= pair_nxt;
    end
  end

  // flag and the parked sample behind it
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_r <= 1'b0;
      pend_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      pend_r <= data_rd && (sample_valid || pend_r);
    end
  end

  // count is registered so a byte pair read sees one value per cycle
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      count_r <= 10'h000;
    end else begin
      count_r <= clamp_count(buffer_fill_count);
    end
  end

  sro_irq u_irq (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .events(ev_pulse),
    .en_wr(irq_en_wr),
    .clr_wr(irq_clr_wr),
    .wdata(wdata[`SRO_EV_W-1:0]),
    .status_r(ev_status),
    .enable_r(ev_enable),
    .irq(irq)
  );

  // read mux; data registers ignore writes
  always @* begin
    rdata_nxt = `SRO_RESET_VAL;
    case (addr)
      `SRO_X_SHORT: rdata_nxt = xs;
      `SRO_Y_SHORT: rdata_nxt = ys;
      `SRO_Z_SHORT: rdata_nxt = zs;
      `SRO_CNT_LOW: rdata_nxt = count_r[7:0];
      `SRO_CNT_HIGH: rdata_nxt = {6'h00, count_r[9:8]};
      `SRO_X_HIGH: rdata_nxt = xh;
      `SRO_X_LOW: rdata_nxt = xl;
      `SRO_Y_HIGH: rdata_nxt = yh;
      `SRO_Y_LOW: rdata_nxt = yl;
      `SRO_Z_HIGH: rdata_nxt = zh;
      `SRO_Z_LOW: rdata_nxt = zl;
      `SRO_IRQ_STAT: rdata_nxt = {6'h00, ev_status};
      `SRO_IRQ_EN: rdata_nxt = {6'h00, ev_enable};
      `SRO_NEW_DATA: rdata_nxt = {7'h00, flag_r};
      default: rdata_nxt = `SRO_RESET_VAL;
    endcase
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= `SRO_RESET_VAL;
    end else if (rd) begin
      rdata <= rdata_nxt;
    end else begin
      rdata <= `SRO_RESET_VAL;
    end
  end

  assign new_data = flag_r;
endmodule // sro_readout
`default_nettype wire

// *** sim/sro_readout_props.sv ***
/* checker for sro_readout, bound at its ports.
 assumes mclk rising edge, sys_rst async high. */
`timescale 1ns/1ps
`default_nettype none
module sro_readout_props (
  // watched ports
  input wire mclk,
  input wire sys_rst,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire sample_valid,
  input wire [13:0] x_accel_value,
  input wire [13:0] y_accel_value,
  input wire [13:0] z_accel_value,
  input wire [9:0] buffer_fill_count,
  input wire new_data,
  input wire irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire dat_rd = rd && (addr inside {[8'h08:8'h0a], [8'h0e:8'h17]});
  wire cnt_ok = buffer_fill_count <= 10'h200;
  property p_pair(h);
    rd && addr == h ##1 rd && addr == h + 8'h01 |=> !new_data;
  endproperty
  AST_RST_ZERO: assert property ($fell(sys_rst) |-> !rdata && !new_data && !irq) else $error("reset");
  AST_CNT_LOW: assert property (rd && addr == 8'h0c && $stable(buffer_fill_count) && cnt_ok
    |=> rdata == ($past(buffer_fill_count) & 10'h0ff)) else $error("cnt low");
  AST_CNT_HIGH: assert property (rd && addr == 8'h0d && $stable(buffer_fill_count) && cnt_ok
    |=> rdata == ($past(buffer_fill_count) >> 8)) else $error("cnt high");
  AST_LOW_RSV: assert property (rd && addr inside {8'h0f, 8'h11, 8'h13} |=> !rdata[1:0]) else $error("low");
  AST_X_PAIR: assert property (p_pair(8'h0e)) else $error("x pair");
  AST_Y_PAIR: assert property (p_pair(8'h10)) else $error("y pair");
  AST_Z_PAIR: assert property (p_pair(8'h12)) else $error("z pair");
  AST_NO_SET: assert property (dat_rd && !new_data |=> !new_data) else $error("flag set");
  cover property (rd && addr == 8'h0e ##1 rd && addr == 8'h0f);
  cover property (dat_rd && sample_valid);
  cover property (irq);
endmodule // sro_readout_props
bind sro_readout sro_readout_props i_props (.mclk, .sys_rst, .addr, .wdata, .wr, .rd, .rdata, .sample_valid,
  .x_accel_value, .y_accel_value, .z_accel_value, .buffer_fill_count, .new_data, .irq);
`default_nettype wire

// *** sim/sro_host.sv ***
/* host model: one register access per mclk cycle.
 assumes rdata answers the read of the previous cycle. */
`timescale 1ns/1ps
`default_nettype none
module sro_host (
  // clock
  input wire mclk,
  // register port
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire [7:0] rdata
);
  initial {addr, wdata, wr, rd} = 18'h0;
  // q is the answer to the read issued one call earlier
  task op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(negedge mclk) q = rdata;
    @(posedge mclk);
  endtask
endmodule // sro_host
`default_nettype wire

// *** sim/tb_top.sv ***
/* self-checking bench: host model, register model, sample source.
 assumes 10 MHz mclk and one access per cycle. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; $display("mismatch %0t %h %h", $time, g, e); end end
module tb_top;
  logic mclk = 0, sys_rst = 1, sample_valid = 0, nd_s, irq_s;
  logic [13:0] ax [3] = '{default: 0};
  logic [5:0] snap [3] = '{default: 0};
  logic [9:0] cnt = 0;
  logic [7:0] q, pe = 0;
  logic [1:0] st = 0, en = 0;
  wire [7:0] addr, wdata, rdata;
  wire wr, rd, new_data, irq;
  int errors = 0, checks = 0, cyc = 0;
  sro_host i_sro_host (.mclk, .addr, .wdata, .wr, .rd, .rdata);
  sro_readout i_sro_readout (.mclk, .sys_rst, .addr, .wdata, .wr, .rd, .rdata, .sample_valid, .new_data, .irq,
    .x_accel_value(ax[0]), .y_accel_value(ax[1]), .z_accel_value(ax[2]), .buffer_fill_count(cnt));
  initial forever #50 mclk = ~mclk;
  always @(negedge mclk) {nd_s, irq_s} = {new_data, irq};
  always @(posedge mclk) if (++cyc == 3000) begin errors++; test_done; end
  function automatic logic [7:0] mdl(input logic [7:0] a);
    int i = (a - 8'h0e) / 2;
    if (a inside {[8'h08:8'h0a]}) return ax[a - 8'h08][13:6];
    if (a == 8'h0c) return cnt > 10'h200 ? 8'h00 : cnt[7:0];
    if (a == 8'h0d) return cnt > 10'h200 ? 8'h02 : {6'h0, cnt[9:8]};
    if (a inside {[8'h0e:8'h13]}) return a[0] ? {snap[i], 2'b00} : ax[i][13:6];
    if (a == 8'h20) return {6'h0, st};
    if (a == 8'h21) return {6'h0, en};
    return 8'h00;
  endfunction
  task bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] e;
    e = r ? mdl(a) : 8'h00;
    if (r && a inside {8'h0e, 8'h10, 8'h12}) snap[(a - 8'h0e) / 2] = ax[(a - 8'h0e) / 2][5:0];
    if (w && a == 8'h21) en = d[1:0];
    if (w && a == 8'h22) st = st & ~d[1:0];
    i_sro_host.op(w, r, a, d, q);
    if (sample_valid) sample_valid <= 1'b0;
    `CHK(q, pe)
    pe = e;
  endtask
  // new sample lands at the next edge; follow with a non-read cycle
  task ld(input logic [9:0] c);
    for (int k = 0; k < 3; k++) ax[k] <= 14'($urandom);
    cnt <= c;
    sample_valid <= 1'b1;
  endtask
  task test_done;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h2148092e));
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    for (int a = 8; a < 8'h24; a++) bus(0, 1, 8'(a), 8'h00);
    for (int a = 8; a < 8'h14; a++) bus(1, 0, 8'(a), 8'(~a));
    for (int i = 0; i < 6; i++) begin
      ld(i == 0 ? 10'h200 : i == 1 ? 10'h3ff : 10'($urandom_range(512)));
      bus(0, 0, 0, 0);
      bus(0, 1, 8'h08 + 8'(i % 3), 0);
      `CHK(nd_s, 1'b1)
      bus(0, 1, 8'h0c, 0);
      bus(0, 1, 8'h0d, 0);
      bus(0, 1, 8'h0e + 8'(2 * (i % 3)), 0);
      // an access between high and low breaks the pair
      if (i == 3) bus(0, 1, 8'h0c, 0);
      bus(0, 1, 8'h0f + 8'(2 * (i % 3)), 0);
      bus(0, 0, 0, 0);
      `CHK(nd_s, i == 3)
    end
    bus(0, 1, 8'h10, 0);
    ld(10'h001);
    bus(0, 1, 8'h11, 0);
    bus(0, 0, 0, 0);
    `CHK(nd_s, 1'b0)
    bus(0, 0, 0, 0);
    `CHK(nd_s, 1'b1)
    bus(0, 1, 8'h0e, 0);
    bus(0, 1, 8'h0f, 0);
    bus(1, 0, 8'h22, 8'h03);
    ld(10'h000);
    st = 2'b11;
    bus(0, 0, 0, 0);
    bus(0, 1, 8'h20, 0);
    bus(1, 0, 8'h21, 8'h01);
    `CHK(irq_s, 1'b0)
    bus(1, 0, 8'h22, 8'h01);
    `CHK(irq_s, 1'b1)
    bus(0, 1, 8'h21, 0);
    `CHK(irq_s, 1'b0)
    bus(0, 0, 0, 0);
    test_done;
  end
endmodule // tb_top
`default_nettype wire
